// ---- timer_capture_reload_cfg.svh ----
/*
 * Constants of the 16-bit capture / reload timer: offsets, fields, resets, dividers.
 * Assumes inclusion by bare name from the timer package and modules.
 */
// Function
// - Overflow flag sets on 16-bit overflow, and on count equal to reload when counting down.
// - Hardware sets overflow flag only when both baud selects are zero; software sets or clears.
// - External flag sets on trigger fall or timer wrap per mode bits; software may set.
// - Edge-set external flag stays until software clears; set flags raise enabled interrupt.
// - Receive baud select picks other timer or this overflow; one forces baud mode.
// - Transmit baud select picks other timer or this overflow; one forces baud mode.
// - External enable lets trigger falls capture or reload, except in baud and down-count modes.
// - Run control starts and stops counting; stopped count holds both bytes except when an enabled trigger fall reloads or clears it.
// - Counter select zero counts prescaled ticks, one counts trigger falling edges.
// - Capture/reload select: zero reloads on overflow or trigger fall, one captures on trigger fall.
// - Any baud select ignores capture/reload select and reloads after each overflow.
// - Control register at C8h holds the eight flag and select bits, seven down to zero.
// - Down-count enable in mode register sets direction in 16-bit auto-reload mode.
// - Capture-reset enable clears count after capture registers latch it.
// - Capture bytes latch count in capture mode, supply reload value otherwise.
`ifndef TIMER_CAPTURE_RELOAD_CFG_SVH
`define TIMER_CAPTURE_RELOAD_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define T2_ADDR_W 8
`define T2_CTRL_OFS 8'hC8
`define T2_MODE_OFS 8'hCC
`define T2_CAPT_OFS 8'hD0
`define T2_CNT_OFS 8'hD4
`define T2_ISTAT_OFS 8'hD8
`define T2_IMASK_OFS 8'hDC
`define T2_CLKC_OFS 8'hE0

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define T2_B_OVF 7
`define T2_B_EXT 6
`define T2_B_RXS 5
`define T2_B_TXS 4
`define T2_B_EXEN 3
`define T2_B_RUN 2
`define T2_B_CT 1
`define T2_B_CPRL 0
`define T2_B_CRST 3
`define T2_B_DOWN_COUNT_ENABLE 0
`define T2_B_PRESC 5
`define T2_I_OVF 0
`define T2_I_EXT 1

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define T2_BYTE_RST 8'h00
`define T2_WORD_RST 16'h0000
`define T2_IRQ_RST 2'h0
`define T2_CNT_MAX 16'hFFFF
`define T2_CNT_ZERO 16'h0000
`define T2_SMODE_1 2'h1
`define T2_SMODE_3 2'h3
`define T2_DIV_SLOW 12
`define T2_DIV_FAST 4

`endif

// ---- timer_capture_reload_pkg.sv ----
/*
 * Types of the 16-bit capture / reload timer.
 * Assumes timer_capture_reload_cfg.svh is on the include path.
 */
package timer_capture_reload_pkg;
    `include "timer_capture_reload_cfg.svh"

    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_RELOAD_UP,
        MODE_RELOAD_DOWN,
        MODE_BAUD
    } timer_mode_e;
endpackage : timer_capture_reload_pkg

// ---- timer_event_if.sv ----
/*
 * Carrier between the trigger/prescale front end and the timer core.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface timer_event_if;
    logic fall_evt;
    logic tick;
    logic prescale_sel;
    modport src (input prescale_sel, output fall_evt, output tick);
    modport dst (output prescale_sel, input fall_evt, input tick);
endinterface : timer_event_if

// ---- trigger_edge_prescale.sv ----
/*
 * Trigger pin synchroniser with falling-edge pulse, and tick prescaler.
 * Assumes trigger pin is a plain level; one clock domain.
 */
`timescale 1ns/1ps
`include "timer_capture_reload_cfg.svh"
module trigger_edge_prescale
    import timer_capture_reload_pkg::*;
#(
    parameter int DIV_SLOW = `T2_DIV_SLOW,
    parameter int DIV_FAST = `T2_DIV_FAST
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Trigger pin
    input wire logic trigger_pin_i,
    // To timer core
    timer_event_if.src evt
);
    if (DIV_SLOW < 1 || DIV_FAST < 1 || DIV_SLOW > 255 || DIV_FAST > 255) begin : g_div_check
        $error("divider out of range");
    end

    logic sync1_q, sync2_q, prev_q, fall_q, tick_q;
    logic [7:0] div_q;
    logic [7:0] div_end;

    assign div_end = evt.prescale_sel ? 8'(DIV_FAST - 1) : 8'(DIV_SLOW - 1);

    // ------------------------------------------------------------------------
    // Trigger edge
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            sync1_q <= trigger_pin_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            fall_q <= prev_q & ~sync2_q;
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (div_q >= div_end) begin
            div_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    assign evt.fall_evt = fall_q;
    assign evt.tick = tick_q;

    a_fall_single: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        fall_q |=> !fall_q) else $error("trigger event longer than one cycle");
endmodule : trigger_edge_prescale

// ---- timer_capture_reload.sv ----
/*
 * 16-bit capture / reload / baud timer with APB register access and interrupt.
 * Assumes a synchronous trigger pin, serial mode from the serial port, APB master.
 */
`timescale 1ns/1ps
`include "timer_capture_reload_cfg.svh"
module timer_capture_reload
    import timer_capture_reload_pkg::*;
#(
    parameter int DIV_SLOW = `T2_DIV_SLOW,
    parameter int DIV_FAST = `T2_DIV_FAST
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`T2_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Trigger pin and serial port
    input wire logic trigger_pin_i,
    input wire logic [1:0] serial_mode_i,
    input wire logic timer1_ovf_i,
    output logic rx_baud_tick_o,
    output logic tx_baud_tick_o,
    // Interrupt
    output logic irq_o
);
    if (`T2_ADDR_W < 8) begin : g_addr_check
        $error("address width too small");
    end

    function automatic logic hit(input logic [`T2_ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a[7:0] == ofs) && (a[`T2_ADDR_W-1:2] == ofs[7:2]);
    endfunction : hit

    // ------------------------------------------------------------------------
    // Front end
    // ------------------------------------------------------------------------
    timer_event_if evt ();

    trigger_edge_prescale #(
        .DIV_SLOW(DIV_SLOW),
        .DIV_FAST(DIV_FAST)
    ) u_front (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .trigger_pin_i(trigger_pin_i),
        .evt(evt)
    );

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic ovf_q, ext_q, rxs_q, txs_q, exen_q, run_q, ct_q, cprl_q;
    logic crst_q, down_count_enable_q, presc_q;
    logic [15:0] cnt_q, cnt_d, rld_q, rld_d;
    logic [1:0] ist_q, imask_q;
    logic pready_q, pslverr_q, irq_q, rx_tick_q, tx_tick_q;
    logic [31:0] prdata_q;
    logic ovf_d, ext_d;
    logic hw_ovf, hw_ext, t2_wrap;

    logic wr_acc, wr_ctrl, wr_mode, wr_capt, wr_cnt, wr_ist, wr_imask, wr_clkc, wr_any;
    logic mapped, baud, exen_eff, fall, cnt_en, mode13;
    timer_mode_e mode;

    assign evt.prescale_sel = presc_q;
    assign fall = evt.fall_evt;

    assign wr_acc = psel_i & penable_i & pwrite_i & pready_q;
    assign wr_ctrl = wr_acc & hit(paddr_i, `T2_CTRL_OFS);
    assign wr_mode = wr_acc & hit(paddr_i, `T2_MODE_OFS);
    assign wr_capt = wr_acc & hit(paddr_i, `T2_CAPT_OFS);
    assign wr_cnt = wr_acc & hit(paddr_i, `T2_CNT_OFS);
    assign wr_ist = wr_acc & hit(paddr_i, `T2_ISTAT_OFS);
    assign wr_imask = wr_acc & hit(paddr_i, `T2_IMASK_OFS);
    assign wr_clkc = wr_acc & hit(paddr_i, `T2_CLKC_OFS);
    assign wr_any = wr_ctrl | wr_mode | wr_capt | wr_cnt | wr_clkc;
    assign mapped = hit(paddr_i, `T2_CTRL_OFS) | hit(paddr_i, `T2_MODE_OFS)
        | hit(paddr_i, `T2_CAPT_OFS) | hit(paddr_i, `T2_CNT_OFS)
        | hit(paddr_i, `T2_ISTAT_OFS) | hit(paddr_i, `T2_IMASK_OFS)
        | hit(paddr_i, `T2_CLKC_OFS);

    // ------------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------------
    assign baud = rxs_q | txs_q;
    assign exen_eff = exen_q & ~baud;
    assign cnt_en = run_q & (ct_q ? fall : evt.tick);
    assign mode13 = (serial_mode_i == `T2_SMODE_1) || (serial_mode_i == `T2_SMODE_3);

    always_comb begin
        if (baud) begin
            mode = MODE_BAUD;
        end else if (cprl_q) begin
            mode = MODE_CAPTURE;
        end else if (down_count_enable_q) begin
            mode = MODE_RELOAD_DOWN;
        end else begin
            mode = MODE_RELOAD_UP;
        end
    end

    // ------------------------------------------------------------------------
    // Counter datapath
    // ------------------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        rld_d = rld_q;
        hw_ovf = 1'b0;
        hw_ext = 1'b0;
        t2_wrap = 1'b0;
        unique case (mode)
            MODE_CAPTURE: begin
                if (cnt_en) begin
                    cnt_d = cnt_q + 16'h0001;
                    hw_ovf = (cnt_q == `T2_CNT_MAX);
                end
                if (fall && exen_eff) begin
                    rld_d = cnt_q;
                    hw_ext = 1'b1;
                    if (crst_q) begin
                        cnt_d = `T2_CNT_ZERO;
                    end
                end
            end
            MODE_RELOAD_UP: begin
                if (cnt_en) begin
                    if (cnt_q == `T2_CNT_MAX) begin
                        cnt_d = rld_q;
                        hw_ovf = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
                if (fall && exen_eff) begin
                    cnt_d = rld_q;
                    hw_ext = 1'b1;
                end
            end
            MODE_RELOAD_DOWN: begin
                if (cnt_en) begin
                    if (cnt_q == rld_q) begin
                        cnt_d = `T2_CNT_MAX;
                        hw_ovf = 1'b1;
                        hw_ext = 1'b1;
                    end else begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
            end
            MODE_BAUD: begin
                if (cnt_en) begin
                    if (cnt_q == `T2_CNT_MAX) begin
                        cnt_d = rld_q;
                        t2_wrap = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 16'h0001;
                    end
                end
            end
        endcase
        if (wr_cnt) begin
            cnt_d = pwdata_i[15:0];
        end
        if (wr_capt) begin
            rld_d = pwdata_i[15:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= `T2_WORD_RST;
            rld_q <= `T2_WORD_RST;
        end else begin
            cnt_q <= cnt_d;
            rld_q <= rld_d;
        end
    end

    // ------------------------------------------------------------------------
    // Control register and flags
    // ------------------------------------------------------------------------
    always_comb begin
        ovf_d = wr_ctrl ? pwdata_i[`T2_B_OVF] : ovf_q;
        ext_d = wr_ctrl ? pwdata_i[`T2_B_EXT] : ext_q;
        if (hw_ovf && !baud) begin
            ovf_d = 1'b1;
        end
        if (hw_ext) begin
            ext_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovf_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            ovf_q <= ovf_d;
            ext_q <= ext_d;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rxs_q <= 1'b0;
            txs_q <= 1'b0;
            exen_q <= 1'b0;
            run_q <= 1'b0;
            ct_q <= 1'b0;
            cprl_q <= 1'b0;
        end else if (wr_ctrl) begin
            rxs_q <= pwdata_i[`T2_B_RXS];
            txs_q <= pwdata_i[`T2_B_TXS];
            exen_q <= pwdata_i[`T2_B_EXEN];
            run_q <= pwdata_i[`T2_B_RUN];
            ct_q <= pwdata_i[`T2_B_CT];
            cprl_q <= pwdata_i[`T2_B_CPRL];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            crst_q <= 1'b0;
            down_count_enable_q <= 1'b0;
            presc_q <= 1'b0;
        end else begin
            if (wr_mode) begin
                crst_q <= pwdata_i[`T2_B_CRST];
                down_count_enable_q <= pwdata_i[`T2_B_DOWN_COUNT_ENABLE];
            end
            if (wr_clkc) begin
                presc_q <= pwdata_i[`T2_B_PRESC];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ist_q <= `T2_IRQ_RST;
            imask_q <= `T2_IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            ist_q[`T2_I_OVF] <= (ist_q[`T2_I_OVF] & ~(wr_ist & pwdata_i[`T2_I_OVF]))
                | (ovf_d & ~ovf_q);
            ist_q[`T2_I_EXT] <= (ist_q[`T2_I_EXT] & ~(wr_ist & pwdata_i[`T2_I_EXT]))
                | (ext_d & ~ext_q);
            if (wr_imask) begin
                imask_q <= pwdata_i[1:0];
            end
            irq_q <= |(ist_q & imask_q);
        end
    end

    // ------------------------------------------------------------------------
    // Baud ticks
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end else begin
            rx_tick_q <= mode13 & (rxs_q ? t2_wrap : timer1_ovf_i);
            tx_tick_q <= mode13 & (txs_q ? t2_wrap : timer1_ovf_i);
        end
    end

    // ------------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel_i & ~penable_i;
            if (psel_i && !penable_i) begin
                pslverr_q <= ~mapped;
                prdata_q <= 32'h0000_0000;
                if (!pwrite_i) begin
                    if (hit(paddr_i, `T2_CTRL_OFS)) begin
                        prdata_q[7:0] <= {ovf_q, ext_q, rxs_q, txs_q,
                            exen_q, run_q, ct_q, cprl_q};
                    end
                    if (hit(paddr_i, `T2_MODE_OFS)) begin
                        prdata_q[`T2_B_CRST] <= crst_q;
                        prdata_q[`T2_B_DOWN_COUNT_ENABLE] <= down_count_enable_q;
                    end
                    if (hit(paddr_i, `T2_CAPT_OFS)) begin
                        prdata_q[15:0] <= rld_q;
                    end
                    if (hit(paddr_i, `T2_CNT_OFS)) begin
                        prdata_q[15:0] <= cnt_q;
                    end
                    if (hit(paddr_i, `T2_ISTAT_OFS)) begin
                        prdata_q[1:0] <= ist_q;
                    end
                    if (hit(paddr_i, `T2_IMASK_OFS)) begin
                        prdata_q[1:0] <= imask_q;
                    end
                    if (hit(paddr_i, `T2_CLKC_OFS)) begin
                        prdata_q[`T2_B_PRESC] <= presc_q;
                    end
                end
            end
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign irq_o = irq_q;
    assign rx_baud_tick_o = rx_tick_q;
    assign tx_baud_tick_o = tx_tick_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_ovf_baud_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (baud && !wr_ctrl) |=> !$rose(ovf_q)) else $error("overflow flag set in baud mode");
    a_up_wrap: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mode == MODE_RELOAD_UP && cnt_en && cnt_q == `T2_CNT_MAX && !wr_any && !fall)
        |=> ovf_q && cnt_q == $past(rld_q)) else $error("up wrap missed");
    a_down_match: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mode == MODE_RELOAD_DOWN && cnt_en && cnt_q == rld_q && !wr_any)
        |=> ovf_q && ext_q && cnt_q == `T2_CNT_MAX) else $error("down match missed");
    a_ext_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (ext_q && !wr_ctrl) |=> ext_q) else $error("external flag dropped");
    a_trig_ignored: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mode == MODE_CAPTURE && fall && !exen_q && !wr_any) |=> $stable(rld_q))
        else $error("capture without enable");
    a_hold_stopped: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!run_q && !wr_any && !(fall && exen_eff)) |=> $stable(cnt_q))
        else $error("count moved while stopped");
    a_capture_latch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mode == MODE_CAPTURE && fall && exen_q && !wr_any)
        |=> rld_q == $past(cnt_q) && ext_q) else $error("capture lost");
    a_capture_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mode == MODE_CAPTURE && fall && exen_q && crst_q && !wr_any)
        |=> cnt_q == `T2_CNT_ZERO) else $error("capture reset missed");
    a_baud_reload: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mode == MODE_BAUD && cnt_en && cnt_q == `T2_CNT_MAX && !wr_any && rxs_q && mode13)
        |=> cnt_q == $past(rld_q) && rx_tick_q) else $error("baud reload missed");
endmodule : timer_capture_reload

// ---- serial_trigger_model.sv ----
/* Far-side model: trigger pin source and the other timer's overflow pulse.
   Assumes requests arrive as one-cycle pulses on clk_i. */
`timescale 1ns/1ps
module serial_trigger_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Requests from the bench
    input wire logic fall_req_i,
    input wire logic ovf_req_i,
    // Pins
    output logic trigger_pin_o,
    output logic timer1_ovf_o
);
    logic [2:0] low_q;
    // Pin idles high; a request holds it low four cycles
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_q <= 3'h0;
        end else if (fall_req_i) begin
            low_q <= 3'h4;
        end else if (low_q != 3'h0) begin
            low_q <= low_q - 3'h1;
        end
    end
    assign trigger_pin_o = (low_q == 3'h0);
    // Overflow of the other timer, one cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer1_ovf_o <= 1'b0;
        end else begin
            timer1_ovf_o <= ovf_req_i;
        end
    end
endmodule : serial_trigger_model

// ---- tb.sv ----
/* Self-checking bench of the capture/reload timer over APB.
   Assumes the design files and serial_trigger_model are compiled first. */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb;
    import timer_capture_reload_pkg::*;
    logic clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, serr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic trig, t1ovf, rx_tick, tx_tick, irq, fall_req, ovf_req;
    logic [1:0] smode;
    int err_count, num_checks, rx_n, tx_n;
    // ------------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------------
    timer_capture_reload u_timer_capture_reload (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .trigger_pin_i(trig), .serial_mode_i(smode), .timer1_ovf_i(t1ovf),
        .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick), .irq_o(irq));
    serial_trigger_model u_serial_trigger_model (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .fall_req_i(fall_req), .ovf_req_i(ovf_req), .trigger_pin_o(trig),
        .timer1_ovf_o(t1ovf));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (rx_tick === 1'b1) rx_n++;
        if (tx_tick === 1'b1) tx_n++;
    end
    // ------------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        @(posedge clk_i);
    endtask : apb
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic pulse_fall();
        fall_req <= 1'b1;
        @(posedge clk_i);
        fall_req <= 1'b0;
        cyc(8);
    endtask : pulse_fall
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_layout();
        apb(0, 8'hC8, 32'h0);
        `CHK(rd, 32'h0)
        apb(1, 8'hC8, 32'hCB);
        apb(0, 8'hC8, 32'h0);
        `CHK(rd, 32'hCB)
        apb(0, 8'hC4, 32'h0);
        `CHK(serr, 1'b1)
        apb(1, 8'hC8, 32'h0);
        apb(1, 8'hD8, 32'h3);
        $display("test layout done");
    endtask : t_layout
    task automatic t_hold();
        apb(1, 8'hD4, 32'h1234);
        cyc(40);
        apb(0, 8'hD4, 32'h0);
        `CHK(rd, 32'h1234)
        apb(1, 8'hC8, 32'h06);
        cyc(30);
        pulse_fall();
        apb(0, 8'hD4, 32'h0);
        `CHK(rd, 32'h1235)
        $display("test hold done");
    endtask : t_hold
    task automatic wait_ovf();
        int n;
        n = 0;
        do begin
            apb(0, 8'hC8, 32'h0);
            n++;
        end while (rd[7] !== 1'b1 && n < 40);
        if (rd[7] !== 1'b1) begin
            err_count++;
            results();
        end
    endtask : wait_ovf
    task automatic t_reload();
        apb(1, 8'hE0, 32'h20);
        apb(1, 8'hD0, 32'hABCD);
        apb(1, 8'hD4, 32'hFFFE);
        apb(1, 8'hDC, 32'h1);
        apb(1, 8'hC8, 32'h04);
        wait_ovf();
        `CHK(rd[7], 1'b1)
        apb(0, 8'hD4, 32'h0);
        `CHK(rd[15:8], 8'hAB)
        cyc(2);
        `CHK(irq, 1'b1)
        apb(1, 8'hC8, 32'h0);
        apb(1, 8'hD8, 32'h3);
        cyc(2);
        `CHK(irq, 1'b0)
        $display("test reload done");
    endtask : t_reload
    task automatic t_down();
        apb(1, 8'hD0, 32'h10);
        apb(1, 8'hD4, 32'h12);
        apb(1, 8'hCC, 32'h01);
        apb(1, 8'hC8, 32'h04);
        wait_ovf();
        `CHK(rd[7:0], 8'hC4)
        apb(0, 8'hD4, 32'h0);
        `CHK(rd[15:8], 8'hFF)
        apb(1, 8'hC8, 32'h0);
        apb(1, 8'hCC, 32'h0);
        apb(1, 8'hD8, 32'h3);
        $display("test down done");
    endtask : t_down
    task automatic t_capture();
        apb(1, 8'hD4, 32'h5678);
        apb(1, 8'hCC, 32'h08);
        apb(1, 8'hDC, 32'h2);
        apb(1, 8'hC8, 32'h09);
        pulse_fall();
        apb(0, 8'hD0, 32'h0);
        `CHK(rd, 32'h5678)
        apb(0, 8'hD4, 32'h0);
        `CHK(rd, 32'h0)
        apb(0, 8'hC8, 32'h0);
        `CHK(rd, 32'h49)
        `CHK(irq, 1'b1)
        apb(1, 8'hC8, 32'h01);
        pulse_fall();
        apb(0, 8'hD0, 32'h0);
        `CHK(rd, 32'h5678)
        apb(1, 8'hD8, 32'h3);
        apb(1, 8'hCC, 32'h0);
        $display("test capture done");
    endtask : t_capture
    task automatic t_baud();
        smode <= 2'h1;
        apb(1, 8'hD0, 32'hFFF0);
        apb(1, 8'hD4, 32'hFFFE);
        apb(1, 8'hC8, 32'h34);
        rx_n = 0;
        tx_n = 0;
        ovf_req <= 1'b1;
        @(posedge clk_i);
        ovf_req <= 1'b0;
        cyc(40);
        `CHK(rx_n, 1)
        `CHK(tx_n, 1)
        apb(0, 8'hC8, 32'h0);
        `CHK(rd[7], 1'b0)
        apb(1, 8'hC8, 32'h0);
        cyc(2);
        rx_n = 0;
        tx_n = 0;
        ovf_req <= 1'b1;
        @(posedge clk_i);
        ovf_req <= 1'b0;
        cyc(4);
        `CHK(rx_n, 1)
        `CHK(tx_n, 1)
        $display("test baud done");
    endtask : t_baud
    initial begin
        clk_i = 0;
        arst_n_i = 0;
        {psel, penable, pwrite, fall_req, ovf_req} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        smode = 2'h0;
        cyc(10);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        t_layout();
        t_hold();
        t_reload();
        t_down();
        t_capture();
        t_baud();
        results();
    end
endmodule : tb
